// [src/mipg_gate.sv]
`default_nettype none

module mipg_gate #(
  parameter int NSRC = mipg_pkg::NSRC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // peripheral request events
  input wire logic [NSRC-1:0] src_req,
  // special request levels
  input wire logic nmi_req,
  input wire logic brk_req,
  input wire logic wdt_req,
  input wire logic step_req,
  input wire logic addr_req,
  // software access to source control words
  input wire logic ctl_wr,
  input wire logic [$clog2(NSRC)-1:0] ctl_wr_idx,
  input wire logic ctl_wr_lvl_en,
  input wire logic [2:0] ctl_wr_lvl,
  input wire logic ctl_wr_req_clr,
  input wire logic [$clog2(NSRC)-1:0] ctl_rd_idx,
  output logic [mipg_pkg::CTL_W-1:0] ctl_rd_data,
  // instruction sequencer
  input wire logic sample_pt,
  input wire logic sw_int,
  input wire logic flag_wr,
  input wire logic flag_wr_ret,
  input wire logic flag_wr_val,
  input wire logic ppl_wr,
  input wire logic ppl_wr_ret,
  input wire logic [2:0] ppl_wr_val,
  // stored state
  output logic flag_out,
  output logic [2:0] processor_priority_level,
  // vector taken
  output logic take,
  output mipg_pkg::mipg_kind_type take_kind,
  output logic [$clog2(NSRC)-1:0] take_idx,
  output logic [2:0] take_lvl
);

  localparam int IW = $clog2(NSRC);

  typedef struct packed {
    logic flag;
    logic [2:0] ppl;
    logic [2:0] ppl_eff;
    logic [NSRC-1:0][2:0] lvl;
    logic [NSRC-1:0][2:0] lvl_eff;
    logic [NSRC-1:0] req;
    logic take;
    mipg_pkg::mipg_kind_type kind;
    logic [IW-1:0] idx;
    logic [2:0] tlvl;
    logic [mipg_pkg::CTL_W-1:0] rd;
  } mipg_state_type;

  mipg_state_type st_r;
  mipg_state_type st_nxt;

  // a beats b on level, then on lower index
  function automatic logic beats(logic [2:0] al, logic [IW-1:0] ai,
                                 logic [2:0] bl, logic [IW-1:0] bi);
    return (al > bl) || ((al == bl) && (ai < bi));
  endfunction : beats

  function automatic logic [IW+3:0] pick(logic [NSRC-1:0] e,
                                         logic [NSRC-1:0][2:0] l);
    logic v;
    logic [IW-1:0] bi;
    logic [2:0] bl;
    v = 1'b0;
    bi = '0;
    bl = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (e[i] && (!v || beats(l[i], IW'(i), bl, bi))) begin
        v = 1'b1;
        bi = IW'(i);
        bl = l[i];
      end
    end
    return {v, bi, bl};
  endfunction : pick

  // delayed level updates
  logic ret_vld;
  logic [2:0] ret_dat;
  logic ld_vld;
  logic [2:0] ld_dat;
  logic lw_vld;
  logic [IW+2:0] lw_dat;

  mipg_dly #(
    .WIDTH(3),
    .DEPTH(mipg_pkg::PPL_RET_CYC)
  ) u_ret_dly (
    .core_clk(core_clk),
    .rst(rst),
    .in_vld(ppl_wr && ppl_wr_ret),
    .in_dat(ppl_wr_val),
    .out_vld(ret_vld),
    .out_dat(ret_dat)
  );

  mipg_dly #(
    .WIDTH(3),
    .DEPTH(mipg_pkg::PPL_LD_CYC)
  ) u_ld_dly (
    .core_clk(core_clk),
    .rst(rst),
    .in_vld(ppl_wr && !ppl_wr_ret),
    .in_dat(ppl_wr_val),
    .out_vld(ld_vld),
    .out_dat(ld_dat)
  );

  mipg_dly #(
    .WIDTH(IW + 3),
    .DEPTH(mipg_pkg::LVL_WR_CYC)
  ) u_lw_dly (
    .core_clk(core_clk),
    .rst(rst),
    .in_vld(ctl_wr && ctl_wr_lvl_en),
    .in_dat({ctl_wr_idx, ctl_wr_lvl}),
    .out_vld(lw_vld),
    .out_dat(lw_dat)
  );

  // values that govern this cycle's sampling
  logic flag_cmp;
  logic [2:0] ppl_cmp;
  logic [NSRC-1:0][2:0] lvl_cmp;
  logic [NSRC-1:0] elig;
  logic p_vld;
  logic [IW-1:0] p_idx;
  logic [2:0] p_lvl;
  mipg_pkg::mipg_kind_type kind_c;
  logic take_c;
  logic beaten_c;

  always_comb begin
    // return applies at once, other writers from the next instruction
    flag_cmp = (flag_wr && flag_wr_ret) ? flag_wr_val : st_r.flag;
    // later-issued return write wins when both exit together
    if (ret_vld) begin
      ppl_cmp = ret_dat;
    end else if (ld_vld) begin
      ppl_cmp = ld_dat;
    end else begin
      ppl_cmp = st_r.ppl_eff;
    end
    for (int i = 0; i < NSRC; i++) begin
      if (lw_vld && (lw_dat[IW+2:3] == IW'(i))) begin
        lvl_cmp[i] = lw_dat[2:0];
      end else begin
        lvl_cmp[i] = st_r.lvl_eff[i];
      end
      // level 0 never exceeds any level; level 7 never exceeded
      elig[i] = st_r.req[i] && (lvl_cmp[i] > ppl_cmp);
    end
    {p_vld, p_idx, p_lvl} = pick(elig, lvl_cmp);
  end

  always_comb begin
    kind_c = mipg_pkg::K_NONE;
    if (sw_int) begin
      kind_c = mipg_pkg::K_SW;
    end else if (sample_pt) begin
      if (nmi_req) begin
        kind_c = mipg_pkg::K_NMI;
      end else if (brk_req) begin
        kind_c = mipg_pkg::K_BRK;
      end else if (wdt_req) begin
        kind_c = mipg_pkg::K_WDT;
      end else if (flag_cmp && p_vld) begin
        kind_c = mipg_pkg::K_PERI;
      end else if (step_req) begin
        kind_c = mipg_pkg::K_STEP;
      end else if (addr_req) begin
        kind_c = mipg_pkg::K_ADDR;
      end
    end
    take_c = (kind_c != mipg_pkg::K_NONE);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.take = take_c;
    if (take_c) begin
      st_nxt.kind = kind_c;
    end
    // each field has its own update path
    if (flag_wr) begin
      st_nxt.flag = flag_wr_val;
    end
    if (ppl_wr) begin
      st_nxt.ppl = ppl_wr_val;
    end
    st_nxt.ppl_eff = ppl_cmp;
    st_nxt.lvl_eff = lvl_cmp;
    if (ctl_wr && ctl_wr_lvl_en) begin
      st_nxt.lvl[ctl_wr_idx] = ctl_wr_lvl;
    end
    if (ctl_wr && ctl_wr_req_clr) begin
      st_nxt.req[ctl_wr_idx] = 1'b0;
    end
    // vector entry overrides an instruction's flag write
    if (take_c) begin
      st_nxt.flag = 1'b0;
    end
    if (kind_c == mipg_pkg::K_PERI) begin
      st_nxt.req[p_idx] = 1'b0;
      st_nxt.ppl = p_lvl;
      st_nxt.ppl_eff = p_lvl;
      st_nxt.idx = p_idx;
      st_nxt.tlvl = p_lvl;
    end
    // a new event beats any clear in the same cycle
    st_nxt.req = st_nxt.req | src_req;
    st_nxt.rd = '0;
    st_nxt.rd[mipg_pkg::LVL_LSB +: mipg_pkg::LVL_W] =
      st_r.lvl[ctl_rd_idx];
    st_nxt.rd[mipg_pkg::REQ_POS] = st_r.req[ctl_rd_idx];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.flag <= mipg_pkg::FLAG_RST;
      st_r.ppl <= mipg_pkg::PPL_RST;
      st_r.ppl_eff <= mipg_pkg::PPL_RST;
      st_r.lvl <= {NSRC{mipg_pkg::LVL_RST}};
      st_r.lvl_eff <= {NSRC{mipg_pkg::LVL_RST}};
      st_r.req <= {NSRC{mipg_pkg::REQ_RST}};
      st_r.kind <= mipg_pkg::K_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctl_rd_data = st_r.rd;
  assign flag_out = st_r.flag;
  assign processor_priority_level = st_r.ppl;
  assign take = st_r.take;
  assign take_kind = st_r.kind;
  assign take_idx = st_r.idx;
  assign take_lvl = st_r.tlvl;

  // independent check of the winner against every eligible source
  always_comb begin
    beaten_c = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (elig[i] && (IW'(i) != p_idx) &&
          beats(lvl_cmp[i], IW'(i), p_lvl, p_idx)) begin
        beaten_c = 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  reset_state_a: assert property ($fell(rst) |->
    !flag_out && (st_r.req == '0) && (st_r.lvl == '0) && !take)
    else $error("state not cleared by reset");

  winner_best_a: assert property (
    !(p_vld && beaten_c))
    else $error("resolver picked a beaten source");

  peri_gate_a: assert property (
    take && (take_kind == mipg_pkg::K_PERI) |->
    $past(flag_cmp) && (|($past(st_r.req) & (NSRC'(1) << take_idx))) &&
    (take_lvl > $past(ppl_cmp)))
    else $error("peripheral taken without its conditions");

  entry_effect_a: assert property (
    take && (take_kind == mipg_pkg::K_PERI) |->
    !flag_out && (processor_priority_level == take_lvl) &&
    (!st_r.req[take_idx] || (|($past(src_req) & (NSRC'(1) << take_idx)))))
    else $error("vector entry did not update state");

  ret_flag_now_a: assert property (
    sample_pt && !sw_int && flag_wr && flag_wr_ret && !flag_wr_val
    |=> !(take && (take_kind == mipg_pkg::K_PERI)))
    else $error("return flag clear not applied at once");

  other_flag_late_a: assert property (
    sample_pt && !sw_int && !nmi_req && !brk_req && !wdt_req &&
    flag_wr && !flag_wr_ret && flag_wr_val && !st_r.flag
    |=> !(take && (take_kind == mipg_pkg::K_PERI)))
    else $error("flag set acted in its own instruction");

  ppl_ret_dly_a: assert property (
    ppl_wr && ppl_wr_ret ##1 (!ppl_wr && !take_c)[*2]
    |-> ppl_cmp == $past(ppl_wr_val, 2))
    else $error("return level not applied after 2 cycles");

  ppl_load_dly_a: assert property (
    ppl_wr && !ppl_wr_ret ##1 (!ppl_wr && !take_c)[*3]
    |-> ppl_cmp == $past(ppl_wr_val, 3))
    else $error("loaded level not applied after 3 cycles");

  lvl_write_dly_a: assert property (
    ctl_wr && ctl_wr_lvl_en ##1 (!(ctl_wr && ctl_wr_lvl_en))[*2]
    |-> lvl_cmp[$past(ctl_wr_idx, 2)] == $past(ctl_wr_lvl, 2))
    else $error("source level not applied after 2 cycles");

  req_set_a: assert property (
    src_req != '0 |=> (st_r.req & $past(src_req)) == $past(src_req))
    else $error("request event lost");

  sw_always_a: assert property (
    sw_int |=> take && (take_kind == mipg_pkg::K_SW))
    else $error("software interrupt not taken");

  nmi_first_a: assert property (
    sample_pt && !sw_int && nmi_req |=> take_kind == mipg_pkg::K_NMI)
    else $error("nmi lost to lower source");

  nest_c: cover property (take && (take_kind == mipg_pkg::K_PERI) &&
    $past(ppl_cmp) != 3'h0);
  tie_c: cover property (take && (take_kind == mipg_pkg::K_PERI) &&
    $past($countones(elig)) > 1);
  held_c: cover property (ret_vld ##0 (flag_cmp && p_vld && sample_pt));
  soft_c: cover property (sw_int && sample_pt && nmi_req);

endmodule : mipg_gate

`default_nettype wire

// [inc/mipg_pkg.sv]
`default_nettype none

package mipg_pkg;

  // field layout of one source control word
  localparam int LVL_W = 3;
  localparam int LVL_LSB = 0;
  localparam int REQ_POS = 3;
  localparam int CTL_W = 8;

  // number of peripheral sources
  localparam int NSRC = 8;

  // reset values
  localparam logic FLAG_RST = 1'b0;
  localparam logic REQ_RST = 1'b0;
  localparam logic [2:0] LVL_RST = 3'h0;
  localparam logic [2:0] PPL_RST = 3'h0;

  // delays, in core_clk cycles after an instruction's last cycle
  localparam int PPL_RET_CYC = 2;
  localparam int PPL_LD_CYC = 3;
  localparam int LVL_WR_CYC = 2;

  // kind of vector taken
  typedef enum logic [7:0] {
    K_NONE = 8'h01,
    K_NMI  = 8'h02,
    K_BRK  = 8'h04,
    K_WDT  = 8'h08,
    K_PERI = 8'h10,
    K_STEP = 8'h20,
    K_ADDR = 8'h40,
    K_SW   = 8'h80
  } mipg_kind_type;

endpackage : mipg_pkg

`default_nettype wire

// [src/mipg_dly.sv]
`default_nettype none

module mipg_dly #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // entry
  input wire logic in_vld,
  input wire logic [WIDTH-1:0] in_dat,
  // exit, visible DEPTH cycles after entry
  output logic out_vld,
  output logic [WIDTH-1:0] out_dat
);

  typedef struct packed {
    logic [DEPTH-1:0] vld;
    logic [DEPTH-1:0][WIDTH-1:0] dat;
  } mipg_dly_type;

  mipg_dly_type st_r;
  mipg_dly_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.vld[0] = in_vld;
    st_nxt.dat[0] = in_dat;
    for (int i = 1; i < DEPTH; i++) begin
      st_nxt.vld[i] = st_r.vld[i-1];
      st_nxt.dat[i] = st_r.dat[i-1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_vld = st_r.vld[DEPTH-1];
  assign out_dat = st_r.dat[DEPTH-1];

endmodule : mipg_dly

`default_nettype wire

// [bench/mipg_src_model.sv]
`default_nettype none

module mipg_src_model #(
  parameter int NSRC = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bench command, request events out
  input wire logic [NSRC-1:0] fire,
  output logic [NSRC-1:0] src_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // src_req repeats fire one cycle later; a fire held high gives a held level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_req <= '0;
    end else begin
      src_req <= fire;
    end
  end
endmodule : mipg_src_model

`default_nettype wire

// [bench/mipg_gate_tb.sv]
`default_nettype none

module mipg_gate_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int N = mipg_pkg::NSRC;
  logic core_clk, rst, ctl_wr, ctl_wr_lvl_en, ctl_wr_req_clr, sample_pt;
  logic sw_int, flag_wr, flag_wr_ret, flag_wr_val, ppl_wr, ppl_wr_ret;
  logic flag_out, take;
  logic [N-1:0] fire, src_req;
  logic [4:0] sp;
  logic [2:0] ctl_wr_idx, ctl_wr_lvl, ctl_rd_idx, ppl_wr_val, ppl;
  logic [2:0] take_idx, take_lvl;
  logic [7:0] ctl_rd_data;
  mipg_pkg::mipg_kind_type take_kind;
  mipg_pkg::mipg_kind_type kinds [5] = '{mipg_pkg::K_NMI, mipg_pkg::K_BRK,
    mipg_pkg::K_WDT, mipg_pkg::K_STEP, mipg_pkg::K_ADDR};
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;

  mipg_src_model #(.NSRC(N)) srcs (.core_clk(core_clk), .rst(rst),
    .fire(fire), .src_req(src_req));

  mipg_gate #(.NSRC(N)) uut (.core_clk(core_clk), .rst(rst),
    .src_req(src_req), .nmi_req(sp[0]), .brk_req(sp[1]), .wdt_req(sp[2]),
    .step_req(sp[3]), .addr_req(sp[4]), .ctl_wr(ctl_wr),
    .ctl_wr_idx(ctl_wr_idx), .ctl_wr_lvl_en(ctl_wr_lvl_en),
    .ctl_wr_lvl(ctl_wr_lvl), .ctl_wr_req_clr(ctl_wr_req_clr),
    .ctl_rd_idx(ctl_rd_idx), .ctl_rd_data(ctl_rd_data),
    .sample_pt(sample_pt), .sw_int(sw_int), .flag_wr(flag_wr),
    .flag_wr_ret(flag_wr_ret), .flag_wr_val(flag_wr_val),
    .ppl_wr(ppl_wr), .ppl_wr_ret(ppl_wr_ret), .ppl_wr_val(ppl_wr_val),
    .flag_out(flag_out), .processor_priority_level(ppl), .take(take),
    .take_kind(take_kind), .take_idx(take_idx), .take_lvl(take_lvl));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic close_out();
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      close_out();
    end
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // software may only clear the request bit, never set it
  task automatic wr_ctl(input logic [2:0] i, input logic le,
                        input logic [2:0] l, input logic clr);
    ctl_wr = 1'b1;
    ctl_wr_idx = i;
    ctl_wr_lvl_en = le;
    ctl_wr_lvl = l;
    ctl_wr_req_clr = clr;
    tick();
    ctl_wr = 1'b0;
  endtask : wr_ctl

  task automatic rd_ctl(input logic [2:0] i, input logic [7:0] e);
    ctl_rd_idx = i;
    tick();
    chk("ctl_rd_data", e, ctl_rd_data);
  endtask : rd_ctl

  task automatic set_flag(input logic ret, input logic v);
    flag_wr = 1'b1;
    flag_wr_ret = ret;
    flag_wr_val = v;
    tick();
    flag_wr = 1'b0;
  endtask : set_flag

  // request bits are set once this returns
  task automatic raise(input logic [N-1:0] m);
    fire = m;
    tick();
    fire = '0;
    tick(2);
  endtask : raise

  task automatic samp(input logic t, input logic [7:0] k);
    sample_pt = 1'b1;
    tick();
    sample_pt = 1'b0;
    chk("take", {7'h0, t}, {7'h0, take});
    if (t) chk("take_kind", k, take_kind);
  endtask : samp

  initial begin
    rst = 1'b1;
    {fire, sp, ctl_wr, ctl_wr_idx, ctl_wr_lvl_en, ctl_wr_lvl} = '0;
    {ctl_wr_req_clr, ctl_rd_idx, sample_pt, sw_int, flag_wr} = '0;
    {flag_wr_ret, flag_wr_val, ppl_wr, ppl_wr_ret, ppl_wr_val} = '0;
    tick(8);
    rst = 1'b0;
    chk("flag_out", 8'h00, {7'h0, flag_out});
    chk("ppl", 8'h00, {5'h0, ppl});
    chk("take_kind", mipg_pkg::K_NONE, take_kind);
    rd_ctl(3'h6, 8'h00);
    set_flag(1'b0, 1'b1);
    raise(8'h40);
    samp(1'b0, 8'h00);
    rd_ctl(3'h6, 8'h08);
    wr_ctl(3'h6, 1'b0, 3'h0, 1'b1);
    rd_ctl(3'h6, 8'h00);
    wr_ctl(3'h3, 1'b1, 3'h4, 1'b0);
    wr_ctl(3'h5, 1'b1, 3'h4, 1'b0);
    wr_ctl(3'h1, 1'b1, 3'h2, 1'b0);
    raise(8'h2a);
    samp(1'b1, mipg_pkg::K_PERI);
    chk("take_idx", 8'h03, {5'h0, take_idx});
    chk("take_lvl", 8'h04, {5'h0, take_lvl});
    chk("flag_out", 8'h00, {7'h0, flag_out});
    chk("ppl", 8'h04, {5'h0, ppl});
    rd_ctl(3'h3, 8'h04);
    rd_ctl(3'h5, 8'h0c);
    set_flag(1'b0, 1'b1);
    samp(1'b0, 8'h00);
    wr_ctl(3'h1, 1'b1, 3'h5, 1'b0);
    tick();
    samp(1'b1, mipg_pkg::K_PERI);
    chk("take_idx", 8'h01, {5'h0, take_idx});
    // return restores level 0 and the flag; level acts two cycles on
    {ppl_wr, ppl_wr_ret, flag_wr, flag_wr_ret, flag_wr_val} = '1;
    ppl_wr_val = 3'h0;
    sample_pt = 1'b1;
    tick();
    {ppl_wr, flag_wr} = '0;
    chk("take", 8'h00, {7'h0, take});
    tick();
    chk("take", 8'h00, {7'h0, take});
    tick();
    sample_pt = 1'b0;
    chk("take", 8'h01, {7'h0, take});
    chk("take_idx", 8'h05, {5'h0, take_idx});
    wr_ctl(3'h2, 1'b1, 3'h6, 1'b0);
    raise(8'h04);
    sample_pt = 1'b1;
    set_flag(1'b0, 1'b1);
    chk("take", 8'h00, {7'h0, take});
    samp(1'b1, mipg_pkg::K_PERI);
    wr_ctl(3'h7, 1'b1, 3'h7, 1'b0);
    raise(8'h80);
    sample_pt = 1'b1;
    set_flag(1'b1, 1'b1);
    sample_pt = 1'b0;
    chk("take", 8'h01, {7'h0, take});
    chk("ppl", 8'h07, {5'h0, ppl});
    set_flag(1'b0, 1'b1);
    raise(8'h80);
    samp(1'b0, 8'h00);
    {ppl_wr, ppl_wr_ret, ppl_wr_val} = {1'b1, 1'b0, 3'h6};
    tick();
    ppl_wr = 1'b0;
    tick();
    sample_pt = 1'b1;
    tick();
    chk("take", 8'h00, {7'h0, take});
    tick();
    sample_pt = 1'b0;
    chk("take", 8'h01, {7'h0, take});
    sp = 5'h1f;
    sw_int = 1'b1;
    samp(1'b1, mipg_pkg::K_SW);
    sw_int = 1'b0;
    for (int i = 0; i < 5; i++) begin
      sp = 5'h1f << i;
      samp(1'b1, kinds[i]);
    end
    sp = 5'h00;
    close_out();
  end
endmodule : mipg_gate_tb

`default_nettype wire
